// >>> rse_exec_top.sv
// execution slice: alu, flags, stack, watchdog, sleep and avalon register port
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rse_exec_top
  import rse_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int WD_TICK     = WD_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             osc_halt
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  rse_state_t         st_q, st_d;
  logic [INSTR_W-1:0] instr_q;
  logic [7:0]         acc_q, pre_q, wdt_q;
  logic               c_q, dc_q, z_q, pd_q, to_q, sleep_q, skip_q;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    stack_q [STACK_DEPTH];
  logic [SP_W-1:0]    sp_q;
  logic [FILE_AW-1:0] faddr_q;
  logic [31:0]        cyc_q, div_q;
  logic [1:0]         rd_cnt_q;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  wire        busy      = (st_q != ST_IDLE);
  wire        wr_ok     = avs_write & ~busy;
  wire        be0       = avs_byteenable[0];
  wire        sel_instr = (avs_address == REG_INSTR);
  wire        sel_acc   = (avs_address == REG_ACC);
  wire        sel_stat  = (avs_address == REG_STATUS);
  wire        sel_pc    = (avs_address == REG_PC);
  wire        sel_wdog  = (avs_address == REG_WDOG);
  wire        sel_faddr = (avs_address == REG_FADDR);
  wire        sel_fdata = (avs_address == REG_FDATA);
  wire        sel_cyc   = (avs_address == REG_CYCLES);
  wire        sel_wake  = (avs_address == REG_WAKE);
  wire        rd_last   = (rd_cnt_q == RD_LAST);
  wire [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{be0}}};
  wire [31:0] instr_wr  = ({12'h000, instr_q} & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] pc_wr     = ({19'h00000, pc_q} & ~be_mask) | (avs_writedata & be_mask);
  wire        issue     = wr_ok & sel_instr & ~sleep_q;

  assign avs_waitrequest = (avs_write & busy) | (avs_read & ~rd_last);
  assign osc_halt        = sleep_q;

  // ---------------------------------------------------------------------------
  // instruction fields and alu
  // ---------------------------------------------------------------------------
  wire rse_op_t      op   = rse_op_t'(instr_q[OP_LSB +: 4]);
  wire               dest = instr_q[DEST_BIT];
  wire [FILE_AW-1:0] fad  = instr_q[FAD_LSB +: FILE_AW];
  wire [7:0]         lit  = instr_q[LIT_LSB +: 8];
  logic [7:0]        opnd;
  logic [7:0]        res;
  logic              new_c, upd_c, upd_dc, upd_z;

  wire        lit_op   = (op == OP_LIT_SUB) | (op == OP_LIT_XOR);
  wire        res_op   = (op >= OP_ROT_L) & (op <= OP_LIT_XOR);
  wire [7:0]  minuend  = lit_op ? lit : opnd;
  wire [8:0]  sub_sum  = {1'b0, minuend} + {1'b0, ~acc_q} + 9'h001;
  wire [4:0]  sub_nib  = {1'b0, minuend[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
  wire        go       = (st_q == ST_EXEC) & ~skip_q;
  wire        wr_acc   = go & res_op & (lit_op | ~dest);
  wire        wr_file  = go & res_op & ~lit_op & dest;
  wire        go_sleep = go & (op == OP_SLEEP);
  wire        go_call  = go & (op == OP_CALL);
  wire        go_ret   = go & (op == OP_RETURN);
  wire        skip_hit = go & (op == OP_SKIP_SET) & opnd[lit[2:0]];
  wire [SP_W-1:0] sp_top = sp_q - 1'b1;
  wire [PC_W-1:0] stack_head = stack_q[sp_top];
  wire [PC_W-1:0] pc_inc = pc_q + 1'b1;

  always_comb begin
    res    = opnd;
    new_c  = c_q;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    upd_z  = 1'b0;
    unique case (op)
      OP_ROT_L: begin
        res   = {opnd[6:0], c_q};
        new_c = opnd[7];
        upd_c = 1'b1;
      end
      OP_ROT_R: begin
        res   = {c_q, opnd[7:1]};
        new_c = opnd[0];
        upd_c = 1'b1;
      end
      OP_LIT_SUB, OP_REG_SUB: begin
        res    = sub_sum[7:0];
        new_c  = sub_sum[8];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_SWAP: res = {opnd[3:0], opnd[7:4]};
      OP_REG_XOR: begin
        res   = acc_q ^ opnd;
        upd_z = 1'b1;
      end
      OP_LIT_XOR: begin
        res   = acc_q ^ lit;
        upd_z = 1'b1;
      end
      default: res = opnd;
    endcase
  end

  // ---------------------------------------------------------------------------
  // data file
  // ---------------------------------------------------------------------------
  wire bus_fwr = wr_ok & sel_fdata & be0;

  rse_regfile_mem #(
    .DW (8),
    .AW (FILE_AW)
  ) u_file (
    .clk   (clk),
    .we    (wr_file | bus_fwr),
    .waddr (wr_file ? fad : faddr_q),
    .wdata (wr_file ? res : avs_writedata[7:0]),
    .raddr (busy ? fad : faddr_q),
    .rdata (opnd)
  );

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (issue) st_d = ST_READ;
      ST_READ: st_d = ST_EXEC;
      ST_EXEC: st_d = (go_call | go_ret) ? ST_TAIL : ST_IDLE;
      ST_TAIL: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= ST_IDLE;
      instr_q <= '0;
      skip_q  <= 1'b0;
      cyc_q   <= '0;
    end else begin
      st_q <= st_d;
      if (issue) instr_q <= instr_wr[INSTR_W-1:0];
      if (st_q == ST_EXEC) skip_q <= skip_hit;
      if ((st_q == ST_EXEC) | (st_q == ST_TAIL)) cyc_q <= cyc_q + 32'd1;
    end
  end

  // ---------------------------------------------------------------------------
  // accumulator and flags
  // ---------------------------------------------------------------------------
  wire wd_tick = (div_q == 32'(WD_TICK - 1));
  wire wd_ovf  = wd_tick & (pre_q == 8'hFF) & (wdt_q == 8'hFF);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= ACC_RST;
      c_q   <= 1'b0;
      dc_q  <= 1'b0;
      z_q   <= 1'b0;
    end else if (go) begin
      if (wr_acc) acc_q <= res;
      if (upd_c) c_q <= new_c;
      if (upd_dc) dc_q <= sub_nib[4];
      if (upd_z) z_q <= (res == 8'h00);
    end else begin
      if (wr_ok & sel_acc & be0) acc_q <= avs_writedata[7:0];
      if (wr_ok & sel_stat & be0) begin
        c_q  <= avs_writedata[SB_C];
        dc_q <= avs_writedata[SB_DC];
        z_q  <= avs_writedata[SB_Z];
      end
    end
  end

  // sleep wins over a watchdog timeout in the same cycle, since it also clears the watchdog
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_q    <= PD_RST;
      to_q    <= TO_RST;
      sleep_q <= 1'b0;
    end else if (go_sleep) begin
      pd_q    <= 1'b0;
      to_q    <= 1'b1;
      sleep_q <= 1'b1;
    end else begin
      if (wd_ovf) to_q <= 1'b0;
      if (wd_ovf | (wr_ok & sel_wake)) sleep_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // watchdog divider, prescaler and counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
      pre_q <= 8'h00;
      wdt_q <= 8'h00;
    end else if (go_sleep) begin
      div_q <= '0;
      pre_q <= 8'h00;
      wdt_q <= 8'h00;
    end else begin
      div_q <= wd_tick ? 32'd0 : div_q + 32'd1;
      if (wd_tick) pre_q <= pre_q + 8'h01;
      if (wd_tick & (pre_q == 8'hFF)) wdt_q <= wdt_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // program counter and stack
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= PC_RST;
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= PC_RST;
      end
    end else if (st_q == ST_EXEC) begin
      if (go_call) begin
        stack_q[sp_q] <= pc_inc;
        sp_q          <= sp_q + 1'b1;
        pc_q          <= {fad[4:0], lit};
      end else if (go_ret) begin
        sp_q <= sp_top;
        pc_q <= stack_head;
      end else begin
        pc_q <= pc_inc;
      end
    end else if (wr_ok & sel_pc) begin
      pc_q <= pc_wr[PC_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------------------
  logic [31:0] stat_w;
  always_comb begin
    stat_w         = 32'h0;
    stat_w[SB_C]   = c_q;
    stat_w[SB_DC]  = dc_q;
    stat_w[SB_Z]   = z_q;
    stat_w[SB_PD]  = pd_q;
    stat_w[SB_TO]  = to_q;
    stat_w[SB_SLP] = sleep_q;
  end

  wire [31:0] rd_mux = sel_instr ? {12'h000, instr_q} :
                       sel_acc   ? {24'h000000, acc_q} :
                       sel_stat  ? stat_w :
                       sel_pc    ? {19'h00000, pc_q} :
                       sel_wdog  ? {16'h0000, pre_q, wdt_q} :
                       sel_faddr ? {25'h0000000, faddr_q} :
                       sel_fdata ? {24'h000000, opnd} :
                       sel_cyc   ? cyc_q : 32'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_cnt_q     <= 2'd0;
      avs_readdata <= 32'h0;
      faddr_q      <= '0;
    end else begin
      if (rd_last) rd_cnt_q <= 2'd0;
      else if (avs_read & ~busy) rd_cnt_q <= rd_cnt_q + 2'd1;
      if (rd_cnt_q == RD_LOAD) avs_readdata <= rd_mux;
      if (wr_ok & sel_faddr & be0) faddr_q <= avs_writedata[FILE_AW-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  logic [7:0]      chk_opnd_q, chk_acc_q;
  logic            chk_c_q;
  logic [PC_W-1:0] chk_head_q;
  always_ff @(posedge clk) begin
    chk_opnd_q <= opnd;
    chk_acc_q  <= acc_q;
    chk_c_q    <= c_q;
    chk_head_q <= stack_head;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rot_left;
    go && op == OP_ROT_L && !dest |=> acc_q == {chk_opnd_q[6:0], chk_c_q} && $stable(z_q) && $stable(dc_q);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("left rotate result wrong");
  property p_rot_right;
    go && op == OP_ROT_R && !dest |=> acc_q == {chk_c_q, chk_opnd_q[7:1]} && $stable(z_q) && $stable(dc_q);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("right rotate result wrong");
  property p_rot_carry;
    go && (op == OP_ROT_L || op == OP_ROT_R) |=> c_q == (op == OP_ROT_L ? chk_opnd_q[7] : chk_opnd_q[0]);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("rotate carry out wrong");
  property p_dest_file;
    go && res_op && !lit_op && dest |=> $stable(acc_q);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination touched accumulator");
  property p_lit_sub;
    go && op == OP_LIT_SUB |=> acc_q == lit - chk_acc_q && c_q == (lit >= chk_acc_q) && z_q == (acc_q == 8'h00);
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");
  property p_reg_sub;
    go && op == OP_REG_SUB && !dest |=> acc_q == chk_opnd_q - chk_acc_q
      && dc_q == (chk_opnd_q[3:0] >= chk_acc_q[3:0]) && c_q == (chk_opnd_q >= chk_acc_q);
  endproperty
  a_reg_sub: assert property (p_reg_sub) else $error("register subtract wrong");
  property p_swap;
    go && op == OP_SWAP && !dest |=> acc_q == {chk_opnd_q[3:0], chk_opnd_q[7:4]} && $stable(c_q) && $stable(z_q);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");
  property p_reg_xor;
    go && op == OP_REG_XOR && !dest |=> acc_q == (chk_acc_q ^ chk_opnd_q) && z_q == (acc_q == 8'h00) && $stable(c_q);
  endproperty
  a_reg_xor: assert property (p_reg_xor) else $error("register xor wrong");
  property p_lit_xor;
    go && op == OP_LIT_XOR |=> acc_q == (chk_acc_q ^ lit) && $stable(c_q) && $stable(dc_q);
  endproperty
  a_lit_xor: assert property (p_lit_xor) else $error("literal xor wrong");
  property p_sleep_flags;
    go_sleep |=> !pd_q && to_q;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
  property p_sleep_wdog;
    go_sleep |=> wdt_q == 8'h00 && pre_q == 8'h00;
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog) else $error("sleep left watchdog running");
  property p_sleep_halt;
    go_sleep |=> osc_halt && st_q == ST_IDLE;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sleep did not halt");
  sequence s_ret;
    go_ret;
  endsequence
  sequence s_ret_tail;
    st_q == ST_TAIL && pc_q == chk_head_q && $stable(c_q) && $stable(z_q) ##1 st_q == ST_IDLE;
  endsequence
  property p_return;
    s_ret |=> s_ret_tail;
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong");
  property p_skip;
    st_q == ST_EXEC && skip_q |=> $stable(acc_q) && !skip_q && st_q == ST_IDLE;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction not discarded");
endmodule
`default_nettype wire

// >>> rse_pkg.sv
// constants and types for the rotate, subtract, swap and xor execution slice
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package rse_pkg;
  // register byte offsets
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_WDOG   = 8'h10;
  localparam logic [7:0] REG_FADDR  = 8'h14;
  localparam logic [7:0] REG_FDATA  = 8'h18;
  localparam logic [7:0] REG_CYCLES = 8'h1C;
  localparam logic [7:0] REG_WAKE   = 8'h20;
  // instruction word fields
  localparam int LIT_LSB  = 0;
  localparam int FAD_LSB  = 8;
  localparam int DEST_BIT = 15;
  localparam int OP_LSB   = 16;
  localparam int INSTR_W  = 20;
  localparam int FILE_AW  = 7;
  localparam int PC_W     = 13;
  // status bit positions
  localparam int SB_C   = 0;
  localparam int SB_DC  = 1;
  localparam int SB_Z   = 2;
  localparam int SB_PD  = 3;
  localparam int SB_TO  = 4;
  localparam int SB_SLP = 5;
  // reset values
  localparam logic [7:0]      ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST  = 13'h0000;
  localparam logic            PD_RST  = 1'b1;
  localparam logic            TO_RST  = 1'b1;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_TICK_NS    = 1000;
  localparam int WD_TICK_CYC   = WD_TICK_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RD_LOAD = 2'd1;
  localparam logic [1:0] RD_LAST = 2'd2;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_ROT_L    = 4'h1,
    OP_ROT_R    = 4'h2,
    OP_LIT_SUB  = 4'h3,
    OP_REG_SUB  = 4'h4,
    OP_SWAP     = 4'h5,
    OP_REG_XOR  = 4'h6,
    OP_LIT_XOR  = 4'h7,
    OP_SLEEP    = 4'h8,
    OP_RETURN   = 4'h9,
    OP_CALL     = 4'hA,
    OP_SKIP_SET = 4'hB
  } rse_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_TAIL = 4'b1000
  } rse_state_t;
endpackage

// >>> rse_regfile_mem.sv
// data file memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module rse_regfile_mem #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the rotate, subtract, swap and xor execution slice
`timescale 1ns/1ps
`default_nettype none
module tb
  import rse_pkg::*;
;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] op;
    logic       d;
    logic [7:0] acc;
    logic [2:0] st;
    logic [7:0] f;
    logic [7:0] lit;
    logic [7:0] eacc;
    logic [7:0] ef;
    logic [2:0] est;
  } rse_row_t;

  logic        clk;
  logic        sys_rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        osc_halt;
  int          errors;
  int          checks_done;
  rse_row_t    rows[$];
  logic [31:0] q;
  logic [31:0] c0;

  rse_exec_top #(.STACK_DEPTH(8), .WD_TICK(2)) uut (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .osc_halt        (osc_halt)
  );

  always #5 clk = ~clk;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // waits for the answer however long it takes; only the run watchdog ends a hang
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(r, exp, what);
  endtask

  function automatic logic [31:0] iw(logic [3:0] op, logic d, logic [6:0] fa, logic [7:0] lit);
    return {12'h000, op, d, fa, lit};
  endfunction

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(REG_ACC, 32'h0000_0000, "acc after reset");
    rdc(REG_STATUS, 32'h0000_0018, "status after reset");
    rdc(REG_PC, 32'h0000_0000, "pc after reset");
  endtask

  // ---------------------------------------------------------------------------
  // watchdog of the run
  // ---------------------------------------------------------------------------
  initial begin
    #400000;
    errors++;
    $display("MISMATCH %0t run did not finish in time", $time);
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk            = 1'b0;
    sys_rst        = 1'b1;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    errors         = 0;
    checks_done    = 0;
    rows.push_back('{OP_ROT_L, 1'b0, 8'h55, 3'b110, 8'h81, 8'h00, 8'h02, 8'h81, 3'b111});
    rows.push_back('{OP_ROT_L, 1'b1, 8'h12, 3'b001, 8'h40, 8'h00, 8'h12, 8'h81, 3'b000});
    rows.push_back('{OP_ROT_R, 1'b1, 8'h33, 3'b000, 8'h01, 8'h00, 8'h33, 8'h00, 3'b001});
    rows.push_back('{OP_ROT_R, 1'b0, 8'h00, 3'b111, 8'hFE, 8'h00, 8'hFF, 8'hFE, 3'b110});
    rows.push_back('{OP_LIT_SUB, 1'b0, 8'h03, 3'b000, 8'h00, 8'h05, 8'h02, 8'h00, 3'b011});
    rows.push_back('{OP_LIT_SUB, 1'b0, 8'h05, 3'b111, 8'h00, 8'h03, 8'hFE, 8'h00, 3'b000});
    rows.push_back('{OP_LIT_SUB, 1'b0, 8'h10, 3'b000, 8'h00, 8'h10, 8'h00, 8'h00, 3'b111});
    rows.push_back('{OP_LIT_SUB, 1'b0, 8'h01, 3'b000, 8'h00, 8'h10, 8'h0F, 8'h00, 3'b001});
    rows.push_back('{OP_REG_SUB, 1'b1, 8'h21, 3'b111, 8'h20, 8'h00, 8'h21, 8'hFF, 3'b000});
    rows.push_back('{OP_REG_SUB, 1'b0, 8'h37, 3'b000, 8'h37, 8'h00, 8'h00, 8'h37, 3'b111});
    rows.push_back('{OP_SWAP, 1'b0, 8'h00, 3'b101, 8'hA5, 8'h00, 8'h5A, 8'hA5, 3'b101});
    rows.push_back('{OP_SWAP, 1'b1, 8'h44, 3'b010, 8'h3C, 8'h00, 8'h44, 8'hC3, 3'b010});
    rows.push_back('{OP_REG_XOR, 1'b0, 8'h0F, 3'b111, 8'hF0, 8'h00, 8'hFF, 8'hF0, 3'b011});
    rows.push_back('{OP_REG_XOR, 1'b1, 8'h5A, 3'b000, 8'h5A, 8'h00, 8'h5A, 8'h00, 3'b100});
    rows.push_back('{OP_LIT_XOR, 1'b0, 8'hFF, 3'b011, 8'h00, 8'hFF, 8'h00, 8'h00, 3'b111});
    rows.push_back('{OP_LIT_XOR, 1'b0, 8'hF0, 3'b100, 8'h00, 8'h0F, 8'hFF, 8'h00, 3'b000});
    rows.push_back('{OP_LIT_XOR, 1'b1, 8'h0F, 3'b000, 8'h33, 8'hF0, 8'hFF, 8'h33, 3'b000});
    rows.push_back('{4'hC, 1'b1, 8'h66, 3'b101, 8'h99, 8'h00, 8'h66, 8'h99, 3'b101});
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(REG_ACC, 32'h0000_0000, "acc after reset");
    rdc(REG_STATUS, 32'h0000_0018, "status after reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0000_0000, "unmapped read");
    foreach (rows[i]) begin
      wr(REG_FADDR, 32'(7'(16 + i)));
      wr(REG_FDATA, {24'h0, rows[i].f});
      wr(REG_ACC, {24'h0, rows[i].acc});
      wr(REG_STATUS, {27'h0, 2'b11, rows[i].st});
      wr(REG_INSTR, iw(rows[i].op, rows[i].d, 7'(16 + i), rows[i].lit));
      rdc(REG_ACC, {24'h0, rows[i].eacc}, "acc result");
      rdc(REG_STATUS, {27'h0, 2'b11, rows[i].est}, "status flags");
      rdc(REG_FDATA, {24'h0, rows[i].ef}, "file result");
    end
    // return restores the pushed pc after two cycles, flags untouched
    wr(REG_PC, 32'h0000_0100);
    wr(REG_INSTR, iw(OP_CALL, 1'b0, 7'h03, 8'h44));
    rdc(REG_PC, 32'h0000_0344, "call target");
    wr(REG_STATUS, 32'h0000_001D);
    bus(REG_CYCLES, 1'b0, 32'h0, c0);
    wr(REG_INSTR, iw(OP_RETURN, 1'b0, 7'h00, 8'h00));
    rdc(REG_PC, 32'h0000_0101, "return pc");
    rdc(REG_STATUS, 32'h0000_001D, "return flags");
    rdc(REG_CYCLES, c0 + 32'd2, "return cycles");
    // skip true discards the next one, skip false does not
    wr(REG_PC, 32'h0000_0050);
    wr(REG_FADDR, 32'h0000_0030);
    wr(REG_FDATA, 32'h0000_0004);
    wr(REG_ACC, 32'h0000_0011);
    wr(REG_INSTR, iw(OP_SKIP_SET, 1'b0, 7'h30, 8'h02));
    wr(REG_INSTR, iw(OP_LIT_XOR, 1'b0, 7'h00, 8'hFF));
    rdc(REG_ACC, 32'h0000_0011, "skipped instruction ran");
    rdc(REG_PC, 32'h0000_0052, "pc after skip");
    wr(REG_INSTR, iw(OP_SKIP_SET, 1'b0, 7'h30, 8'h03));
    wr(REG_INSTR, iw(OP_LIT_XOR, 1'b0, 7'h00, 8'hFF));
    rdc(REG_ACC, 32'h0000_00EE, "unskipped instruction lost");
    // lane 0 missing leaves an 8-bit register alone
    avs_byteenable <= 4'hE;
    wr(REG_ACC, 32'h0000_0077);
    avs_byteenable <= 4'hF;
    rdc(REG_ACC, 32'h0000_00EE, "write without lane 0");
    // sleep clears watchdog and power-down flag, sets timeout, halts
    repeat (1100) @(posedge clk);
    bus(REG_WDOG, 1'b0, 32'h0, q);
    chk({31'h0, q[7:0] == 8'h00}, 32'h0, "watchdog not running");
    wr(REG_STATUS, 32'h0000_0018);
    wr(REG_INSTR, iw(OP_SLEEP, 1'b0, 7'h00, 8'h00));
    rdc(REG_STATUS, 32'h0000_0030, "sleep status");
    chk({31'h0, osc_halt}, 32'h1, "oscillator not halted");
    bus(REG_WDOG, 1'b0, 32'h0, q);
    chk({24'h0, q[7:0]}, 32'h0, "watchdog count after sleep");
    chk({31'h0, q[15:8] < 8'h08}, 32'h1, "prescaler after sleep");
    wr(REG_INSTR, iw(OP_LIT_XOR, 1'b0, 7'h00, 8'hFF));
    rdc(REG_ACC, 32'h0000_00EE, "instruction ran while asleep");
    wr(REG_WAKE, 32'h0000_0001);
    chk({31'h0, osc_halt}, 32'h0, "still halted after wake");
    do_reset();
    stop_test();
  end
endmodule
`default_nettype wire
